// file: flash_led_control_registers.sv
// serial register bank and control core of a flash led driver
// How it works
// - repeated start and address with read bit; we ack then send data.
// - no master ack needed after a data byte; master then stops.
// - index increments after each read; master ack streams next register.
// - supply-up enables analog blocks, and the thermistor per the watch bit in ready mode; else only serial port.
// - flash active is strobe pin AND flash arm bit AND supply-up, with no fault flag latched and the flash counter nonzero.
// - flash only with supply-up set; current follows flash level field.
// - steady light bit in ready mode gives torch from steady level.
// - watch bit enables thermistor in ready; always on in torch/flash.
// - flash limit code n gives n times 100 ms maximum flash.
// - entering flash counts down from the loaded limit value.
// - count at zero clears arm bit and asserts attention at once.
// - flash limit field keeps its value; counter never writes back.
// - index is steady level in torch, flash level plus five in flash.
// - nonzero indicator level write restarts the timer; zero turns off.
// - indicator source works only in ready mode.
// - indicator time code n gives n times 100 ms; 15 stays on.
// - indicator on/off follows level writes only, never time writes.
// - short flag sets on mirror high in torch/flash; read clears it.
// - flash running flag is high exactly while flash is active.
// - attention low on latched status; released by a status read.
// - unlatched flags are live; latched flags hold until status read.
// - flash counter accumulates across strobes; control write reloads it.
// - slave address chosen from four by the select pin.
`timescale 1ns/1ps
module flash_led_control_registers #(
  parameter int TICK_CYCLES = flash_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              resetn,
  // serial port, open drain data
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe,
  // address select strap, 0 gnd 1 supply 2 data 3 clock
  input  wire logic [1:0]        addr_sel,
  // flash strobe pin
  input  wire logic              flash_strobe_pin,
  // analog sense and drive
  input  wire flash_pkg::sense_s sense,
  output flash_pkg::drive_s      drive,
  // open drain attention pin, active low
  output logic                   attention_out_n,
  output logic                   attention_oe
);
  import flash_pkg::*;

  typedef enum logic [2:0] {
    st_idle     = 3'b000,
    st_addr     = 3'b001,
    st_ack_addr = 3'b010,
    st_index    = 3'b011,
    st_write    = 3'b100,
    st_ack_data = 3'b101,
    st_read     = 3'b110,
    st_mack     = 3'b111
  } port_state_e;

  // serial port state
  port_state_e st_q, st_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [7:0]  sh_q, sh_d;
  logic [7:0]  idx_q, idx_d;
  logic        rw_q, rw_d;
  logic        oe_q, oe_d;
  logic        scl_q, sda_q;
  logic [6:0]  addr_q;
  logic        addr_done_q;
  logic        wr_en, load_now;
  logic        start_cond, stop_cond, scl_rise, scl_fall;
  logic [7:0]  rd_byte;

  // register and control state
  control_byte_s       ctl_q, ctl_d;
  current_level_byte_s lvl_q, lvl_d;
  indicator_byte_s     ind_q, ind_d;
  condition_byte_s     lat_q, lat_d, set_vec, view;
  logic                timeout_q, timeout_d;
  logic [3:0]          fcnt_q, fcnt_d;
  logic [3:0]          icnt_q, icnt_d;
  logic                irun_q, irun_d;
  logic [TICK_WIDTH-1:0] tick_q, tick_d;
  logic                atn_q, atn_d;
  drive_s              drive_q, drive_d;
  logic                tick, fault, supply, flash_req, flash_act;
  logic                torch, ready, stat_clear, ind_steady;

  function automatic logic [7:0] read_reg(input logic [7:0] index,
                                          input logic [7:0] c, l, i, s);
    logic [7:0] r;
    unique case (index)
      REG_CONTROL:   r = c;
      REG_LEVEL:     r = l;
      REG_INDICATOR: r = i;
      REG_CONDITION: r = s;
      default:       r = RESET_BYTE;
    endcase
    return r;
  endfunction : read_reg

  // bus line conditions, inputs taken as synchronous
  assign start_cond = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_cond  = scl_in & scl_q & ~sda_q & sda_in;
  assign scl_rise   = scl_in & ~scl_q;
  assign scl_fall   = ~scl_in & scl_q;
  assign rd_byte    = read_reg(idx_q, ctl_q, lvl_q, ind_q, view);
  assign sda_out    = 1'b0;
  assign sda_oe     = oe_q;

  always_comb begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    sh_d     = sh_q;
    idx_d    = idx_q;
    rw_d     = rw_q;
    oe_d     = oe_q;
    wr_en    = 1'b0;
    load_now = 1'b0;
    if (start_cond) begin
      st_d  = st_addr;
      cnt_d = COUNT_ZERO;
      oe_d  = 1'b0;
    end else if (stop_cond) begin
      st_d = st_idle;
      oe_d = 1'b0;
    end else begin
      unique case (st_q)
        st_idle: ;
        st_addr, st_index, st_write: begin
          if (scl_rise && cnt_q != BITS_PER_BYTE) begin
            sh_d  = {sh_q[6:0], sda_in};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
            cnt_d = COUNT_ZERO;
            if (st_q == st_addr) begin
              if (sh_q[7:1] == addr_q) begin
                oe_d = 1'b1;
                rw_d = sh_q[0];
                st_d = st_ack_addr;
              end else begin
                st_d = st_idle;
              end
            end else if (st_q == st_index) begin
              idx_d = sh_q;
              oe_d  = 1'b1;
              st_d  = st_ack_data;
            end else begin
              wr_en = 1'b1;
              idx_d = idx_q + 8'h01;
              oe_d  = 1'b1;
              st_d  = st_ack_data;
            end
          end
        end
        st_ack_addr: begin
          if (scl_fall) begin
            oe_d = 1'b0;
            if (rw_q) begin
              load_now = 1'b1;
            end else begin
              st_d = st_index;
            end
          end
        end
        st_ack_data: begin
          if (scl_fall) begin
            oe_d = 1'b0;
            st_d = st_write;
          end
        end
        st_read: begin
          if (scl_fall) begin
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == LAST_BIT) begin
              oe_d = 1'b0;
              st_d = st_mack;
            end else begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = ~sh_q[6];
            end
          end
        end
        st_mack: begin
          // no ack from master just ends the stream
          if (scl_rise && sda_in) begin
            st_d = st_idle;
          end else if (scl_fall) begin
            load_now = 1'b1;
          end
        end
      endcase
    end
    if (load_now) begin
      sh_d    = rd_byte;
      idx_d   = idx_q + 8'h01;
      oe_d    = ~rd_byte[7];
      cnt_d   = COUNT_ZERO;
      st_d    = st_read;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_q  <= st_idle;
      cnt_q <= COUNT_ZERO;
      sh_q  <= RESET_BYTE;
      idx_q <= RESET_BYTE;
      rw_q  <= 1'b0;
      oe_q  <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
      sh_q  <= sh_d;
      idx_q <= idx_d;
      rw_q  <= rw_d;
      oe_q  <= oe_d;
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // strap caught once after reset release, never under the reset itself
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      addr_q      <= {SLAVE_ADDR_BASE, 2'b00};
      addr_done_q <= 1'b0;
    end else if (!addr_done_q) begin
      addr_q      <= {SLAVE_ADDR_BASE, addr_sel};
      addr_done_q <= 1'b1;
    end
  end

  // operating mode decode
  assign supply     = ctl_q.supply_up_bit;
  assign fault      = lat_q.lamp_open_flag | lat_q.thermistor_hot_flag |
                      lat_q.die_overheat_flag | lat_q.output_short_flag;
  assign flash_req  = supply & ctl_q.flash_arm_bit & flash_strobe_pin &
                      ~fault;
  assign flash_act  = flash_req & (fcnt_q != COUNT_ZERO);
  assign torch      = supply & ctl_q.steady_light_bit & ~flash_act &
                      ~fault;
  assign ready      = supply & ~flash_act & ~torch;
  assign tick       = (tick_q == TICK_WIDTH'(TICK_CYCLES - 1));
  assign stat_clear = load_now & (idx_q == REG_CONDITION);
  assign ind_steady = (ind_q.indicator_time_field == INDICATOR_STEADY);

  // live flags merge into the latched ones for reading
  always_comb begin
    view                       = lat_q;
    view.flash_running_flag    = flash_act;
    view.coil_overcurrent_flag = sense.coil_peak;
  end

  always_comb begin
    set_vec                      = '0;
    set_vec.lamp_short_flag      = sense.mirror_high & (torch | flash_act);
    set_vec.lamp_open_flag       = sense.vout_high & (torch | flash_act);
    set_vec.thermistor_warn_flag = sense.thermistor_warn &
                                   drive_d.thermistor_enable;
    set_vec.thermistor_hot_flag  = sense.thermistor_hot &
                                   drive_d.thermistor_enable;
    set_vec.die_overheat_flag    = sense.die_hot & supply;
    set_vec.output_short_flag    = sense.vout_short & supply;
  end

  always_comb begin
    ctl_d     = ctl_q;
    lvl_d     = lvl_q;
    ind_d     = ind_q;
    fcnt_d    = fcnt_q;
    icnt_d    = icnt_q;
    irun_d    = irun_q;
    tick_d    = tick ? '0 : tick_q + TICK_WIDTH'(1);
    // flash safety countdown, never written back to the limit field
    if (tick && flash_act) begin
      fcnt_d = fcnt_q - 4'h1;
    end
    // indicator on-time, source drops the cycle after the count empties
    if (tick && irun_q && !ind_steady && icnt_q != COUNT_ZERO) begin
      icnt_d = icnt_q - 4'h1;
    end
    if (!ind_steady && icnt_q == COUNT_ZERO) begin
      irun_d = 1'b0;
    end
    if (wr_en) begin
      unique case (idx_q)
        REG_CONTROL: begin
          ctl_d  = control_byte_s'(sh_q);
          fcnt_d = sh_q[3:0];
        end
        REG_LEVEL: lvl_d = current_level_byte_s'(sh_q);
        REG_INDICATOR: begin
          ind_d  = indicator_byte_s'(sh_q);
          // only the level nibble starts or stops the source
          irun_d = (sh_q[7:4] != COUNT_ZERO);
          icnt_d = sh_q[3:0];
        end
        default: ;
      endcase
    end
    // expiry wins over a same-cycle write of the arm bit
    if (flash_req && fcnt_q == COUNT_ZERO) begin
      ctl_d.flash_arm_bit = 1'b0;
    end
    // a new event beats the clear of the same read
    timeout_d = (timeout_q & ~stat_clear) |
                (flash_req & (fcnt_q == COUNT_ZERO));
    lat_d     = condition_byte_s'((lat_q & ~{8{stat_clear}}) |
                                  set_vec);
    atn_d     = (|lat_d) | timeout_d;
  end
  always_comb begin
    drive_d                   = '0;
    drive_d.analog_enable     = supply;
    drive_d.thermistor_enable = supply &
                                (ctl_q.thermistor_watch_bit | ~ready);
    drive_d.flash_active      = flash_act;
    drive_d.steady_on         = torch;
    drive_d.indicator_on      = ready & irun_q &
                                (ind_q.indicator_level_field != COUNT_ZERO);
    drive_d.indicator_level   = ind_q.indicator_level_field;
    if (flash_act) begin
      drive_d.combined_current_index = {1'b0, lvl_q.flash_level_field} +
                                       FLASH_INDEX_OFFSET;
    end else if (torch) begin
      drive_d.combined_current_index = {1'b0, lvl_q.steady_level_field};
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctl_q     <= control_byte_s'(RESET_BYTE);
      lvl_q     <= current_level_byte_s'(RESET_BYTE);
      ind_q     <= indicator_byte_s'(RESET_BYTE);
      lat_q     <= condition_byte_s'(RESET_BYTE);
      timeout_q <= 1'b0;
      fcnt_q    <= COUNT_ZERO;
      icnt_q    <= COUNT_ZERO;
      irun_q    <= 1'b0;
      tick_q    <= '0;
      atn_q     <= 1'b0;
      drive_q   <= '0;
    end else begin
      ctl_q     <= ctl_d;
      lvl_q     <= lvl_d;
      ind_q     <= ind_d;
      lat_q     <= lat_d;
      timeout_q <= timeout_d;
      fcnt_q    <= fcnt_d;
      icnt_q    <= icnt_d;
      irun_q    <= irun_d;
      tick_q    <= tick_d;
      atn_q     <= atn_d;
      drive_q   <= drive_d;
    end
  end
  assign drive           = drive_q;
  assign attention_out_n = 1'b0;
  assign attention_oe    = atn_q;
endmodule : flash_led_control_registers

// file: flash_led_control_registers_sva.sv
// port assertions for the flash led control core
`timescale 1ns/1ps
module flash_led_control_registers_sva
  import flash_pkg::*;
#(
  parameter int TICK_CYCLES = 20
) (
  // clock and reset
  input wire logic              clock,
  input wire logic              resetn,
  // serial port
  input wire logic              scl_in,
  input wire logic              sda_in,
  input wire logic              sda_out,
  input wire logic              sda_oe,
  input wire logic [1:0]        addr_sel,
  // flash, sense, drive
  input wire logic              flash_strobe_pin,
  input wire flash_pkg::sense_s sense,
  input wire flash_pkg::drive_s drive,
  input wire logic              attention_out_n,
  input wire logic              attention_oe
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  property p_strobe_gate;
    $fell(flash_strobe_pin) |-> ##[1:3] !drive.flash_active;
  endproperty
  a_strobe_gate: assert property (p_strobe_gate)
    else $error("flash outlived strobe");

  property p_needs_supply;
    !drive.analog_enable |-> !(drive.flash_active || drive.steady_on
      || drive.indicator_on || drive.thermistor_enable);
  endproperty
  a_needs_supply: assert property (p_needs_supply)
    else $error("output active without supply");

  property p_flash_index;
    drive.flash_active |-> drive.combined_current_index inside {[4'h5:4'hc]};
  endproperty
  a_flash_index: assert property (p_flash_index)
    else $error("flash index out of range");

  property p_torch_index;
    drive.steady_on && !drive.flash_active
      |-> drive.combined_current_index <= 4'h7;
  endproperty
  a_torch_index: assert property (p_torch_index)
    else $error("torch index out of range");

  property p_indicator_ready;
    drive.indicator_on |-> !drive.steady_on && !drive.flash_active;
  endproperty
  a_indicator_ready: assert property (p_indicator_ready)
    else $error("indicator on outside ready");

  property p_thermistor_on;
    drive.steady_on || drive.flash_active |-> drive.thermistor_enable;
  endproperty
  a_thermistor_on: assert property (p_thermistor_on)
    else $error("thermistor off while lit");

  property p_sda_change;
    $changed(sda_oe) |-> !scl_in;
  endproperty
  a_sda_change: assert property (p_sda_change)
    else $error("data moved while clock high");

  property p_timeout_alert;
    $fell(drive.flash_active) && flash_strobe_pin && $past(flash_strobe_pin)
      |-> ##[0:2] attention_oe;
  endproperty
  a_timeout_alert: assert property (p_timeout_alert)
    else $error("timeout without attention");

  property p_alert_release;
    $fell(attention_oe) |-> !scl_in;
  endproperty
  a_alert_release: assert property (p_alert_release)
    else $error("attention dropped outside a read");

  property p_short_alert;
    sense.mirror_high ##1 drive.steady_on |-> ##[0:2] attention_oe;
  endproperty
  a_short_alert: assert property (p_short_alert)
    else $error("short not flagged");
endmodule : flash_led_control_registers_sva

bind flash_led_control_registers flash_led_control_registers_sva
  #(.TICK_CYCLES(TICK_CYCLES)) i_sva (
  .clock(clock), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel),
  .flash_strobe_pin(flash_strobe_pin), .sense(sense), .drive(drive),
  .attention_out_n(attention_out_n), .attention_oe(attention_oe)
);

// file: flash_pkg.sv
// shared constants and carriers for the flash led control core
package flash_pkg;

  // register indices on the serial port
  localparam logic [7:0] REG_CONTROL   = 8'h00;
  localparam logic [7:0] REG_LEVEL     = 8'h01;
  localparam logic [7:0] REG_INDICATOR = 8'h02;
  localparam logic [7:0] REG_CONDITION = 8'h03;
  localparam logic [7:0] RESET_BYTE    = 8'h00;

  // slave address 0110000..0110011, low two bits from the select pin
  localparam logic [4:0] SLAVE_ADDR_BASE = 5'h0c;
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
  localparam logic [3:0] LAST_BIT        = 4'h7;

  // current index and timer encodings
  localparam logic [3:0] FLASH_INDEX_OFFSET = 4'h5;
  localparam logic [3:0] INDICATOR_STEADY   = 4'hf;
  localparam logic [3:0] COUNT_ZERO         = 4'h0;

  // time base
  localparam int CLOCK_MHZ   = 125;
  localparam int TICK_MS     = 100;
  localparam int TICK_CYCLES = TICK_MS * 1000 * CLOCK_MHZ;
  localparam int TICK_WIDTH  = 24;

  typedef struct packed {
    logic       supply_up_bit;
    logic       flash_arm_bit;
    logic       steady_light_bit;
    logic       thermistor_watch_bit;
    logic [3:0] flash_limit_field;
  } control_byte_s;

  typedef struct packed {
    logic       unused_hi;
    logic [2:0] steady_level_field;
    logic       unused_lo;
    logic [2:0] flash_level_field;
  } current_level_byte_s;

  typedef struct packed {
    logic [3:0] indicator_level_field;
    logic [3:0] indicator_time_field;
  } indicator_byte_s;

  typedef struct packed {
    logic lamp_short_flag;
    logic flash_running_flag;
    logic lamp_open_flag;
    logic thermistor_warn_flag;
    logic thermistor_hot_flag;
    logic die_overheat_flag;
    logic coil_overcurrent_flag;
    logic output_short_flag;
  } condition_byte_s;

  // analog sense inputs
  typedef struct packed {
    logic mirror_high;
    logic vout_high;
    logic thermistor_warn;
    logic thermistor_hot;
    logic die_hot;
    logic coil_peak;
    logic vout_short;
  } sense_s;

  // controls toward the analog section
  typedef struct packed {
    logic       analog_enable;
    logic       thermistor_enable;
    logic       flash_active;
    logic       steady_on;
    logic       indicator_on;
    logic [3:0] combined_current_index;
    logic [3:0] indicator_level;
  } drive_s;

endpackage : flash_pkg

// file: host_model.sv
// two-wire bus master standing in for the host processor
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic  clock,
  // bus, data level as resolved on the wire
  input  wire logic  sda_wire,
  output logic       scl,
  output logic       sda_drv,
  // read results and refused bytes
  output logic       rd_valid,
  output logic [7:0] rd_byte,
  output int         nacks
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    rd_valid = 1'b0;
    rd_byte = 8'h00;
    nacks = 0;
  end

  // four clocks a phase, four times the minimum the core needs
  task automatic half();
    repeat (4) @(posedge clock);
  endtask : half

  task automatic put_bit(input logic b);
    sda_drv <= b;
    half();
    scl <= 1'b1;
    half();
    scl <= 1'b0;
    half();
  endtask : put_bit

  task automatic get_bit(output logic b);
    sda_drv <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    b = sda_wire;
    scl <= 1'b0;
    half();
  endtask : get_bit

  task automatic start_bus();
    sda_drv <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_drv <= 1'b0;
    half();
    scl <= 1'b0;
    half();
  endtask : start_bus

  task automatic stop_bus();
    sda_drv <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_drv <= 1'b1;
    half();
  endtask : stop_bus

  task automatic send_byte(input logic [7:0] v);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(v[i]);
    get_bit(a);
    if (a) nacks++;
  endtask : send_byte

  task automatic write_reg(input logic [6:0] dev, input logic [7:0] idx,
                           input logic [7:0] v);
    start_bus();
    send_byte({dev, 1'b0});
    send_byte(idx);
    send_byte(v);
    stop_bus();
  endtask : write_reg

  task automatic read_regs(input logic [6:0] dev, input logic [7:0] idx,
                           input int n);
    logic [7:0] v;
    start_bus();
    send_byte({dev, 1'b0});
    send_byte(idx);
    start_bus();
    send_byte({dev, 1'b1});
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) get_bit(v[i]);
      rd_byte <= v;
      rd_valid <= 1'b1;
      put_bit(k == n - 1);
      rd_valid <= 1'b0;
    end
    stop_bus();
  endtask : read_regs
endmodule : host_model

// file: tb.sv
// self-checking bench for the flash led control core
`timescale 1ns/1ps
module tb;
  import flash_pkg::*;
  localparam int TICK = 50;
  logic        clock;
  logic        resetn;
  logic [1:0]  addr_sel;
  logic        flash_strobe_pin;
  sense_s      sense;
  drive_s      drive;
  logic        sda_out;
  logic        sda_oe;
  logic        attention_out_n;
  logic        attention_oe;
  logic        scl;
  logic        sda_drv;
  logic        sda_wire;
  logic        rd_valid;
  logic [7:0]  rd_byte;
  int          nacks;
  int          n_errors;
  int          tests_run;
  int          seed;
  logic [6:0]  dev;
  logic [7:0]  lvl;
  logic [7:0]  exp_q[$];

  // open drain data line with its pull-up
  assign sda_wire = sda_drv & ~(sda_oe & ~sda_out);
  always #4 clock = ~clock;

  flash_led_control_registers #(.TICK_CYCLES(TICK))
    i_flash_led_control_registers (
    .clock(clock), .resetn(resetn), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel),
    .flash_strobe_pin(flash_strobe_pin), .sense(sense), .drive(drive),
    .attention_out_n(attention_out_n), .attention_oe(attention_oe)
  );

  host_model i_host_model (
    .clock(clock), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv),
    .rd_valid(rd_valid), .rd_byte(rd_byte), .nacks(nacks)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    tests_run++;
    if (seen !== want) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic final_report();
    $display("errors %0d, checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    i_host_model.write_reg(dev, idx, v);
  endtask : wr

  task automatic rd1(input logic [7:0] idx, input logic [7:0] e);
    exp_q.push_back(e);
    i_host_model.read_regs(dev, idx, 1);
  endtask : rd1

  // compare away from the edge that launched the byte
  always @(posedge rd_valid) begin
    @(negedge clock);
    check(16'(exp_q.size() != 0), 16'h0001);
    if (exp_q.size() != 0) check(rd_byte, exp_q.pop_front());
  end

  initial begin
    cyc(60000);
    n_errors++;
    final_report();
  end

  initial begin
    seed = 32'h932c624d;
    clock = 1'b0;
    resetn = 1'b0;
    flash_strobe_pin = 1'b0;
    sense = '0;
    n_errors = 0;
    tests_run = 0;
    addr_sel = 2'($random(seed));
    lvl = 8'($random(seed)) & 8'h77;
    dev = {SLAVE_ADDR_BASE, addr_sel};
    cyc(10);
    resetn <= 1'b1;
    cyc(2);
    check({3'h0, drive}, 16'h0000);
    check(attention_oe, 1'b0);
    check({sda_out, attention_out_n}, 16'h0000);
    i_host_model.write_reg(dev ^ 7'h01, REG_CONTROL, 8'h80);
    repeat (4) exp_q.push_back(8'h00);
    i_host_model.read_regs(dev, REG_CONTROL, 4);
    wr(REG_LEVEL, lvl);
    wr(REG_CONTROL, 8'h80);
    check(drive.analog_enable, 1'b1);
    check(drive.thermistor_enable, 1'b0);
    wr(REG_CONTROL, 8'h90);
    check(drive.thermistor_enable, 1'b1);
    exp_q.push_back(8'h90);
    exp_q.push_back(lvl);
    i_host_model.read_regs(dev, REG_CONTROL, 2);
    wr(REG_CONTROL, 8'ha0);
    check(drive.steady_on, 1'b1);
    check(drive.combined_current_index, {1'b0, lvl[6:4]});
    check(drive.thermistor_enable, 1'b1);
    sense.mirror_high <= 1'b1;
    cyc(8);
    sense.mirror_high <= 1'b0;
    check(attention_oe, 1'b1);
    rd1(REG_CONDITION, 8'h80);
    check(attention_oe, 1'b0);
    sense.coil_peak <= 1'b1;
    rd1(REG_CONDITION, 8'h02);
    check(attention_oe, 1'b0);
    sense.coil_peak <= 1'b0;
    wr(REG_CONTROL, 8'h80);
    wr(REG_INDICATOR, 8'h52);
    check(drive.indicator_on, 1'b1);
    check(drive.indicator_level, 4'h5);
    cyc(2 * TICK + 10);
    check(drive.indicator_on, 1'b0);
    wr(REG_INDICATOR, 8'h3f);
    cyc(16 * TICK);
    check(drive.indicator_on, 1'b1);
    wr(REG_CONTROL, 8'ha0);
    check(drive.indicator_on, 1'b0);
    wr(REG_CONTROL, 8'h80);
    wr(REG_INDICATOR, 8'h0f);
    check(drive.indicator_on, 1'b0);
    wr(REG_CONTROL, 8'hcf);
    flash_strobe_pin <= 1'b1;
    cyc(4);
    check(drive.flash_active, 1'b1);
    check(drive.combined_current_index, 4'(lvl[2:0]) + 4'h5);
    rd1(REG_CONDITION, 8'h40);
    flash_strobe_pin <= 1'b0;
    cyc(4);
    check(drive.flash_active, 1'b0);
    wr(REG_CONTROL, 8'h83);
    flash_strobe_pin <= 1'b1;
    cyc(4);
    check(drive.flash_active, 1'b0);
    wr(REG_CONTROL, 8'hc3);
    check(drive.flash_active, 1'b1);
    cyc(2 * TICK - 30);
    check(drive.flash_active, 1'b1);
    cyc(TICK + 35);
    check(drive.flash_active, 1'b0);
    check(attention_oe, 1'b1);
    flash_strobe_pin <= 1'b0;
    rd1(REG_CONTROL, 8'h83);
    rd1(REG_CONDITION, 8'h00);
    check(attention_oe, 1'b0);
    sense.die_hot <= 1'b1;
    cyc(4);
    sense.die_hot <= 1'b0;
    check(attention_oe, 1'b1);
    rd1(REG_CONDITION, 8'h04);
    rd1(REG_CONDITION, 8'h00);
    check(attention_oe, 1'b0);
    check(16'(exp_q.size()), 16'h0000);
    check(16'(nacks), 16'h0003);
    final_report();
  end
endmodule : tb
